/* File: dv/srctl_host_props.sv */
// pin-timing assertions for the sram controller
`timescale 1ns/1ps
`include "srctl_map.svh"
module srctl_host_props (
  input wire logic                     clk,           // clock
  input wire logic                     sys_rst,       // reset
  input wire logic                     req_valid,     // request
  input wire logic                     req_ready,     // taken
  input wire logic [`SRCTL_ADDR_W-1:0] req_addr,      // address in
  input wire logic                     rsp_valid,     // read done
  input wire logic [`SRCTL_ADDR_W-1:0] address_pins,  // sram address
  input wire logic                     chip_en_n,     // select
  input wire logic                     out_en_n,      // read drive
  input wire logic                     write_en_n,    // store
  input wire logic                     busy,               // cycle in progress
  input wire logic [`SRCTL_DATA_W-1:0] shared_data_drv,    // write data
  input wire logic                     shared_data_drv_en  // drive enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_open; (!chip_en_n && !out_en_n && write_en_n)[*5]; endsequence
  sequence s_wr_open; (!chip_en_n && !write_en_n)[*4]; endsequence
  property p_take; req_valid && req_ready |=> !chip_en_n && address_pins == $past(req_addr); endproperty
  a_take: assert property (p_take) else $error("request not put on pins");
  property p_rd; $fell(out_en_n) |-> s_rd_open ##1 (chip_en_n && rsp_valid); endproperty
  a_rd: assert property (p_rd) else $error("read access window wrong");
  property p_wr; $fell(write_en_n) |-> s_wr_open ##1 (chip_en_n && write_en_n); endproperty
  a_wr: assert property (p_wr) else $error("write pulse wrong");
  property p_wdat;
    $fell(write_en_n) |=> ($stable(shared_data_drv) && $stable(address_pins) && shared_data_drv_en)[*4];
  endproperty
  a_wdat: assert property (p_wdat) else $error("write data or address moved");
  property p_rdwe; !out_en_n |-> write_en_n; endproperty
  a_rdwe: assert property (p_rdwe) else $error("write enable low in read");
  property p_clash; shared_data_drv_en |-> out_en_n; endproperty
  a_clash: assert property (p_clash) else $error("pins driven while read enabled");
  property p_busy; req_valid && req_ready |=> busy[*5]; endproperty
  a_busy: assert property (p_busy) else $error("busy dropped inside a cycle");
  property p_rsp; rsp_valid |=> !rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("read data pulse too long");
  property p_idle; !busy |-> chip_en_n && out_en_n && write_en_n && !shared_data_drv_en; endproperty
  a_idle: assert property (p_idle) else $error("sram left selected while idle");
endmodule // srctl_host_props
bind srctl_host srctl_host_props u_props (.*);

/* File: dv/srctl_host_test.sv */
// self-checking bench for the sram controller
`timescale 1ns/1ps
`include "srctl_map.svh"
module srctl_host_test;
  logic clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, rsp_valid, req_ready, busy, ce_n, oe_n, we_n, d_oe, m_oe;
  logic [`SRCTL_ADDR_W-1:0] req_addr = '0, addr_pins, a;
  logic [`SRCTL_DATA_W-1:0] req_wdata = '0, rsp_rdata, d_o, m_d, pins, d;
  logic [`SRCTL_DATA_W-1:0] shadow [2**`SRCTL_ADDR_W];
  logic [`SRCTL_DATA_W-1:0] exp_q [$];
  logic hung = 0;
  int failures = 0, total_checks = 0, seed = 32'he75af4d7, i, n;
  // released pins show the inverse so a stale value cannot pass
  assign pins = d_oe ? d_o : m_oe ? m_d : ~m_d;
  srctl_host dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .busy(busy), .address_pins(addr_pins), .chip_en_n(ce_n), .out_en_n(oe_n),
    .write_en_n(we_n), .shared_data_pins(pins), .shared_data_drv(d_o), .shared_data_drv_en(d_oe));
  srctl_sram_model mem (.address_pins(addr_pins), .chip_en_n(ce_n), .out_en_n(oe_n),
    .write_en_n(we_n), .wr_data(pins), .rd_data(m_d), .rd_oe(m_oe));
  initial forever #2 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_rd(input logic [`SRCTL_DATA_W-1:0] e, input logic [`SRCTL_DATA_W-1:0] s);
    total_checks++;
    if (s !== e) begin failures++; $display("mismatch rsp_rdata exp %h got %h", e, s); end
  endtask
  // held from one falling edge until a rising edge sees ready
  task automatic req(input logic w, input logic [`SRCTL_ADDR_W-1:0] ad, input logic [`SRCTL_DATA_W-1:0] wd);
    int k;
    k = 0;
    if (hung) return;
    @(negedge clk);
    req_valid = 1; req_write = w; req_addr = ad; req_wdata = wd;
    while (req_ready !== 1'b1 && k < 64) begin @(negedge clk); k++; end
    if (k == 64) begin failures++; hung = 1; return; end
    @(negedge clk);
    req_valid = 0;
    if (w) shadow[ad] = wd; else exp_q.push_back(shadow[ad]);
  endtask
  always @(negedge clk) if (rsp_valid === 1'b1) chk_rd(exp_q.size() ? exp_q.pop_front() : 'x, rsp_rdata);
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 0;
    req(1, '0, 8'h5a); req(1, '1, 8'ha5); req(1, '0, 8'hc3); req(0, '0, '0); req(0, '1, '0);
    for (i = 0; i < 40; i++) begin
      a = 11'($random(seed)); d = 8'($random(seed));
      req(1, a, d); req(0, a, '0); req(0, '1, '0);
    end
    n = 0;
    while (exp_q.size() && n < 64) begin @(negedge clk); n++; end
    if (n == 64) failures++;
    finish_test();
  end
endmodule // srctl_host_test

/* File: dv/srctl_sram_model.sv */
// behavioural 2k x 8 async sram
`timescale 1ns/1ps
`include "srctl_map.svh"
module srctl_sram_model #(parameter int ACC_NS = 19) (
  input  wire logic [`SRCTL_ADDR_W-1:0] address_pins, // word select
  input  wire logic                     chip_en_n,    // select, low
  input  wire logic                     out_en_n,     // read drive, low
  input  wire logic                     write_en_n,   // store, low
  input  wire logic [`SRCTL_DATA_W-1:0] wr_data,      // pin level seen
  output logic      [`SRCTL_DATA_W-1:0] rd_data,      // driven level
  output logic                          rd_oe         // high while driving
);
  logic [`SRCTL_DATA_W-1:0] mem [2**`SRCTL_ADDR_W];
  logic wr_act;
  assign wr_act = !chip_en_n && !write_en_n;
  assign rd_oe = !chip_en_n && !out_en_n && write_en_n;
  // stored as the overlap ends, whichever enable rises first
  always @(negedge wr_act) mem[address_pins] = wr_data;
  // just under the access limit so the capture edge never races the model
  initial rd_data = '0;
  // every change restarts the access: the inverse of the target stands until then
  always @(address_pins or rd_oe) begin
    rd_data = ~mem[address_pins];
    rd_data <= #(ACC_NS) mem[address_pins];
  end
endmodule // srctl_sram_model

/* File: hw/srctl_host.sv */
// host-side controller that sequences reads and writes of a 2k x 8 async sram
`timescale 1ns/1ps
`include "srctl_map.svh"

module srctl_host (
  input  wire logic                       clk,            // 250 MHz clock
  input  wire logic                       sys_rst,        // sync reset, active high
  input  wire logic                       req_valid,      // request present
  output logic                            req_ready,      // request taken this cycle
  input  wire logic                       req_write,      // 1 write, 0 read
  input  wire logic [`SRCTL_ADDR_W-1:0]   req_addr,       // word address
  input  wire logic [`SRCTL_DATA_W-1:0]   req_wdata,      // write data
  output logic                            rsp_valid,      // read data pulse
  output logic [`SRCTL_DATA_W-1:0]        rsp_rdata,      // read data
  output logic                            busy,           // cycle in progress
  output logic [`SRCTL_ADDR_W-1:0]        address_pins,   // to sram address
  output logic                            chip_en_n,      // to sram chip enable
  output logic                            out_en_n,       // to sram output enable
  output logic                            write_en_n,     // to sram write enable
  input  wire logic [`SRCTL_DATA_W-1:0]   shared_data_pins,   // level seen on sram data pins
  output logic [`SRCTL_DATA_W-1:0]        shared_data_drv,    // value driven onto data pins
  output logic                            shared_data_drv_en  // high while we drive pins
);

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  srctl_pkg::srctl_state_t                state_q, state_d;
  logic [`SRCTL_CNT_W-1:0]                cnt_q, cnt_d;
  logic                                   take;      // request accepted at this edge
  logic                                   cnt_last;  // last cycle of a timed phase
  logic                                   rd_done;   // access time used up
  logic                                   wr_done;   // write pulse long enough

  // ready is combinational so a waiting request goes on the first idle edge
  assign req_ready = (state_q == srctl_pkg::SRCTL_IDLE);
  assign take      = req_valid && req_ready;
  assign cnt_last  = (cnt_q == `SRCTL_CNT_W'(1));
  // both timed phases end on the cycle the counter reaches one
  assign rd_done   = (state_q == srctl_pkg::SRCTL_READ) && cnt_last;
  assign wr_done   = (state_q == srctl_pkg::SRCTL_WRITE) && cnt_last;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // counts are least times rounded up to whole cycles
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      srctl_pkg::SRCTL_IDLE: begin
        if (take) begin
          if (req_write) begin
            cnt_d   = `SRCTL_CNT_W'(`SRCTL_WR_CYC);
            state_d = srctl_pkg::SRCTL_WRITE;
          end else begin
            cnt_d   = `SRCTL_CNT_W'(`SRCTL_RD_CYC);
            state_d = srctl_pkg::SRCTL_READ;
          end
        end
      end

      srctl_pkg::SRCTL_READ: begin
        cnt_d = cnt_q - `SRCTL_CNT_W'(1);
        if (cnt_last) begin
          state_d = srctl_pkg::SRCTL_RECOVER;
        end
      end

      srctl_pkg::SRCTL_WRITE: begin
        cnt_d = cnt_q - `SRCTL_CNT_W'(1);
        if (cnt_last) begin
          state_d = srctl_pkg::SRCTL_RECOVER;
        end
      end

      srctl_pkg::SRCTL_RECOVER: begin
        // one idle cycle: release data after the write end, no bus fight
        state_d = srctl_pkg::SRCTL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= srctl_pkg::SRCTL_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------
  // sram pins
  // ----------------------------------------
  logic [`SRCTL_ADDR_W-1:0]               addr_q, addr_d;
  logic [`SRCTL_DATA_W-1:0]               wdata_q, wdata_d;
  logic                                   ce_n_q, ce_n_d;
  logic                                   oe_n_q, oe_n_d;
  logic                                   we_n_q, we_n_d;
  logic                                   drv_q, drv_d;

  // pins change only on a take, at a phase end or in recover
  always_comb begin
    addr_d  = addr_q;
    wdata_d = wdata_q;
    ce_n_d  = ce_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    drv_d   = drv_q;
    if (take) begin
      // address and enables launch on the same edge: valid by the fall
      addr_d  = req_addr;
      wdata_d = req_wdata;
      ce_n_d  = 1'b0;
      if (req_write) begin
        we_n_d = 1'b0;
        oe_n_d = 1'b1;
        drv_d  = 1'b1;
      end else begin
        we_n_d = 1'b1;
        oe_n_d = 1'b0;
      end
    end

    if (rd_done) begin
      ce_n_d = 1'b1;
      oe_n_d = 1'b1;
    end

    if (wr_done) begin
      // both rise together; data and address stay one more cycle
      we_n_d = 1'b1;
      ce_n_d = 1'b1;
    end

    if (state_q == srctl_pkg::SRCTL_RECOVER) begin
      drv_d = 1'b0;
    end
  end

  // controls leave reset deasserted so the sram stays deselected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q  <= '0;
      wdata_q <= '0;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      drv_q   <= 1'b0;
    end else begin
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      ce_n_q  <= ce_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      drv_q   <= drv_d;
    end
  end

  // ----------------------------------------
  // read capture
  // ----------------------------------------
  logic [`SRCTL_DATA_W-1:0]               rdata_q, rdata_d;
  logic                                   rvld_q, rvld_d;

  always_comb begin
    rdata_d = rdata_q;
    rvld_d  = 1'b0;
    if (rd_done) begin
      // sampled only after the full access time from both edges
      rdata_d = shared_data_pins;
      rvld_d  = 1'b1;
    end
  end

  // rdata holds until the next read; rvld is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
      rvld_q  <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvld_q  <= rvld_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // request side
  assign busy               = (state_q != srctl_pkg::SRCTL_IDLE);
  assign rsp_valid          = rvld_q;
  assign rsp_rdata          = rdata_q;

  // sram side: every pin straight from a flop, so no glitch reaches it
  assign address_pins       = addr_q;
  assign chip_en_n          = ce_n_q;
  assign out_en_n           = oe_n_q;
  assign write_en_n         = we_n_q;
  assign shared_data_drv    = wdata_q;
  assign shared_data_drv_en = drv_q;

endmodule // srctl_host

/* File: inc/srctl_map.svh */
// timing and geometry constants for the async sram controller
`ifndef SRCTL_MAP_SVH
`define SRCTL_MAP_SVH

`define SRCTL_ADDR_W        11
`define SRCTL_DATA_W        8
`define SRCTL_CLK_PS        4000
// figures in ps
`define SRCTL_ADDR_TO_VALID_PS       20000
`define SRCTL_OUTEN_TO_VALID_PS      10000
`define SRCTL_SELECT_TO_VALID_PS     20000
`define SRCTL_OUTPUT_HOLD_ADDR_PS    5000
`define SRCTL_WRITE_PULSE_PS         15000
`define SRCTL_DATA_SETUP_END_PS      10000
`define SRCTL_ADDR_SETUP_END_PS      15000
`define SRCTL_DATA_HOLD_END_PS       0
`define SRCTL_ADDR_HOLD_END_PS       0
// least times round up; the read is captured on the edge that ends the wait, with no extra cycle
`define SRCTL_CYC_UP(ps)    (((ps) + `SRCTL_CLK_PS - 1) / `SRCTL_CLK_PS)
`define SRCTL_RD_CYC        `SRCTL_CYC_UP(`SRCTL_SELECT_TO_VALID_PS)
`define SRCTL_WR_CYC        `SRCTL_CYC_UP(`SRCTL_WRITE_PULSE_PS)
`define SRCTL_CNT_W         4

`endif

/* File: inc/srctl_pkg.sv */
// types for the async sram controller
package srctl_pkg;
  typedef enum logic [1:0] {
    SRCTL_IDLE,
    SRCTL_READ,
    SRCTL_WRITE,
    SRCTL_RECOVER
  } srctl_state_t;
endpackage
